// File: hw/deser_out_err_regs.sv
// Output polarity, stagger, error output and address translation registers.
// Assumes a host-side control channel presents single-cycle register strobes on CLK_I,
// and that video, error events and sync config come from logic on the same clock.
// Function
// - Horizontal inversion bit inverts HS output, or data bit 1 without encoding.
// - Double-rate match bit reads 1 when both settings agree; resets 0.
// - With auto-clear set, clear both error counters 1 us after error asserts.
// - With auto-clear clear, counters and error output are never cleared automatically.
// - Error source field picks detected, corrected, or either over threshold.
// - Translation pair A: 7-bit source and destination in bits 7..1.
// - Translation pair B: 7-bit source and destination in bits 7..1.
// - Sync encoding enable selects sync outputs versus plain data bits.
// - Detected-error limit, 8 bits, reset zero, compared with detected counter.
// - Corrected-error limit, 8 bits, reset zero, compared with corrected counter.
`timescale 1ns/1ns
`default_nettype none
module deser_out_err_regs (
  input wire logic CLK_I,                 // 50 MHz system clock
  input wire logic RST_B_I,               // Asynchronous reset, active low
  input wire logic [7:0] REG_ADDR_I,      // Register address
  input wire logic [7:0] REG_WDATA_I,     // Register write data
  input wire logic REG_WR_I,              // Write strobe, one cycle
  input wire logic REG_RD_I,              // Read strobe, one cycle
  output logic [7:0] REG_RDATA_O,         // Read data, registered
  output logic REG_ACK_O,                 // Access done, one cycle
  input wire logic SYNC_ENCODE_ENABLE_I,  // Sync encoding on the link
  input wire logic [23:0] PAR_DATA_I,     // Recovered parallel word
  input wire logic VS_I,                  // Recovered vertical sync
  input wire logic HS_I,                  // Recovered horizontal sync
  output logic [23:0] PAR_DATA_O,         // Parallel output word
  output logic VS_O,                      // Vertical sync output
  output logic HS_O,                      // Horizontal sync output
  output logic DOUBLE_RATE_MATCH_O,       // Double-rate setting matches serializer
  input wire logic DET_ERR_I,             // Detected error event, one cycle
  input wire logic COR_ERR_I,             // Corrected error event, one cycle
  output logic ERR_O,                     // Error output, active high
  input wire logic [6:0] FWD_ADDR_I,      // Forwarded I2C address
  input wire logic FWD_VALID_I,           // Forwarded address valid
  output logic [6:0] XLATE_ADDR_O,        // Translated I2C address
  output logic XLATE_VALID_O,             // Translated address valid
  output logic XLATE_HIT_O                // Translation applied
);
  logic rst_s1_r, rst_n;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  function automatic logic above(input logic [7:0] cnt, input logic [7:0] lim);
    above = (cnt > lim);
  endfunction

  function automatic logic [7:0] count_up(input logic [7:0] cnt, input logic clr,
                                          input logic inc);
    // An event in the clearing cycle is kept
    if (clr) count_up = inc ? 8'h01 : 8'h00;
    else if (inc && cnt != 8'hFF) count_up = cnt + 8'h01;
    else count_up = cnt;
  endfunction

  logic [7:0] ctrl_r, src_a_r, dst_a_r, src_b_r, dst_b_r, det_lim_r, cor_lim_r;
  logic [7:0] det_cnt_r, cor_cnt_r;
  logic err_r;
  logic [5:0] ac_cnt_r;
  deser_cfg_pkg::autoclr_state_t ac_state_r;

  wire wr_ctrl = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_CTRL);
  wire wr_src_a = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_SRC_A);
  wire wr_dst_a = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_DST_A);
  wire wr_src_b = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_SRC_B);
  wire wr_dst_b = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_DST_B);
  wire wr_det_lim = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_DET_LIM);
  wire wr_cor_lim = REG_WR_I && (REG_ADDR_I == deser_cfg_pkg::OFS_COR_LIM);
  wire [7:0] addr_wdata = REG_WDATA_I & deser_cfg_pkg::ADDR_WMASK;

  wire vs_inv = ctrl_r[deser_cfg_pkg::BIT_VS_INV];
  wire hs_inv = ctrl_r[deser_cfg_pkg::BIT_HS_INV];
  wire stag_dis = ctrl_r[deser_cfg_pkg::BIT_STAG];
  wire auto_clr = ctrl_r[deser_cfg_pkg::BIT_AUTO];
  wire [1:0] esel = ctrl_r[deser_cfg_pkg::ESEL_LSB +: 2];

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= deser_cfg_pkg::CTRL_RST;
      src_a_r <= deser_cfg_pkg::ADDR_RST;
      dst_a_r <= deser_cfg_pkg::ADDR_RST;
      src_b_r <= deser_cfg_pkg::ADDR_RST;
      dst_b_r <= deser_cfg_pkg::ADDR_RST;
      det_lim_r <= deser_cfg_pkg::LIM_RST;
      cor_lim_r <= deser_cfg_pkg::LIM_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= REG_WDATA_I & deser_cfg_pkg::CTRL_WMASK;
      if (wr_src_a) src_a_r <= addr_wdata;
      if (wr_dst_a) dst_a_r <= addr_wdata;
      if (wr_src_b) src_b_r <= addr_wdata;
      if (wr_dst_b) dst_b_r <= addr_wdata;
      if (wr_det_lim) det_lim_r <= REG_WDATA_I;
      if (wr_cor_lim) cor_lim_r <= REG_WDATA_I;
    end
  end

  // Read mux; unmapped addresses read zero and writes to them are dropped
  logic [7:0] rd_mux;
  always_comb begin
    case (REG_ADDR_I)
      deser_cfg_pkg::OFS_CTRL: rd_mux = ctrl_r;
      deser_cfg_pkg::OFS_SRC_A: rd_mux = src_a_r;
      deser_cfg_pkg::OFS_DST_A: rd_mux = dst_a_r;
      deser_cfg_pkg::OFS_SRC_B: rd_mux = src_b_r;
      deser_cfg_pkg::OFS_DST_B: rd_mux = dst_b_r;
      deser_cfg_pkg::OFS_DET_LIM: rd_mux = det_lim_r;
      deser_cfg_pkg::OFS_DET_CNT: rd_mux = det_cnt_r;
      deser_cfg_pkg::OFS_COR_LIM: rd_mux = cor_lim_r;
      deser_cfg_pkg::OFS_COR_CNT: rd_mux = cor_cnt_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA_O <= 8'h00;
      REG_ACK_O <= 1'b0;
    end else begin
      REG_ACK_O <= REG_RD_I | REG_WR_I;
      if (REG_RD_I) REG_RDATA_O <= rd_mux;
    end
  end

  assign DOUBLE_RATE_MATCH_O = ctrl_r[deser_cfg_pkg::BIT_DRM];

  // Output stage; sync bits ride in the low half so they never lag with staggering
  wire enc = SYNC_ENCODE_ENABLE_I;
  wire [23:0] data_pol = PAR_DATA_I ^ {22'h000000, hs_inv & ~enc, vs_inv & ~enc};
  wire vs_nxt = enc ? (VS_I ^ vs_inv) : 1'b0;
  wire hs_nxt = enc ? (HS_I ^ hs_inv) : 1'b0;
  logic [11:0] hi_stage_r;
  // Staggering costs one cycle of skew on the upper half in exchange for lower switching noise
  wire [11:0] hi_nxt = stag_dis ? data_pol[23:12] : hi_stage_r;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PAR_DATA_O <= 24'h000000;
      hi_stage_r <= 12'h000;
      VS_O <= 1'b0;
      HS_O <= 1'b0;
    end else begin
      hi_stage_r <= data_pol[23:12];
      PAR_DATA_O <= {hi_nxt, data_pol[11:0]};
      VS_O <= vs_nxt;
      HS_O <= hs_nxt;
    end
  end

  // Error output and automatic counter clearing
  wire det_over = above(det_cnt_r, det_lim_r);
  wire cor_over = above(cor_cnt_r, cor_lim_r);
  wire err_nxt = (esel == deser_cfg_pkg::ESEL_DET) ? det_over :
                 (esel == deser_cfg_pkg::ESEL_COR) ? cor_over :
                 (det_over | cor_over);
  // Gated by the enable too, so dropping auto-clear on the last wait cycle cannot clear
  wire ac_clear = auto_clr && (ac_state_r == deser_cfg_pkg::AC_WAIT) &&
                  (ac_cnt_r == deser_cfg_pkg::AC_LAST);

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      det_cnt_r <= deser_cfg_pkg::CNT_RST;
      cor_cnt_r <= deser_cfg_pkg::CNT_RST;
      err_r <= 1'b0;
    end else begin
      det_cnt_r <= count_up(det_cnt_r, ac_clear, DET_ERR_I);
      cor_cnt_r <= count_up(cor_cnt_r, ac_clear, COR_ERR_I);
      err_r <= err_nxt;
    end
  end
  assign ERR_O = err_r;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ac_state_r <= deser_cfg_pkg::AC_IDLE;
      ac_cnt_r <= deser_cfg_pkg::AC_CNT_RST;
    end else begin
      case (ac_state_r)
        deser_cfg_pkg::AC_IDLE: begin
          ac_cnt_r <= deser_cfg_pkg::AC_CNT_RST;
          if (auto_clr && err_r) ac_state_r <= deser_cfg_pkg::AC_WAIT;
        end
        deser_cfg_pkg::AC_WAIT: begin
          ac_cnt_r <= ac_cnt_r + 6'h01;
          if (!auto_clr) ac_state_r <= deser_cfg_pkg::AC_IDLE;
          else if (ac_clear) ac_state_r <= deser_cfg_pkg::AC_DONE;
        end
        deser_cfg_pkg::AC_DONE: begin
          if (!err_r) ac_state_r <= deser_cfg_pkg::AC_IDLE;
        end
        default: ac_state_r <= deser_cfg_pkg::AC_IDLE;
      endcase
    end
  end

  addr_xlate u_xlate (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .src_a_i(src_a_r[7:1]),
    .dst_a_i(dst_a_r[7:1]),
    .src_b_i(src_b_r[7:1]),
    .dst_b_i(dst_b_r[7:1]),
    .addr_i(FWD_ADDR_I),
    .valid_i(FWD_VALID_I),
    .addr_o(XLATE_ADDR_O),
    .valid_o(XLATE_VALID_O),
    .hit_o(XLATE_HIT_O)
  );

  a_vs_invert: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (enc && vs_inv) |=> (VS_O != $past(VS_I)))
    else $error("vertical sync not inverted");
  a_bit0_invert: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!enc && vs_inv) |=> (PAR_DATA_O[0] != $past(PAR_DATA_I[0])))
    else $error("data bit 0 not inverted");
  a_hs_bit1_invert: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!enc && hs_inv) |=> (PAR_DATA_O[1] != $past(PAR_DATA_I[1])) && !HS_O)
    else $error("data bit 1 not inverted");
  a_sync_plain: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (enc && !vs_inv && !hs_inv) |=> (VS_O == $past(VS_I)) && (HS_O == $past(HS_I)))
    else $error("sync altered without inversion");
  a_stagger_off: assert property (@(posedge CLK_I) disable iff (!rst_n)
    stag_dis |=> (PAR_DATA_O[23:12] == $past(PAR_DATA_I[23:12])))
    else $error("upper half lags with stagger disabled");
  a_stagger_on: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!stag_dis && $past(!stag_dis)) |=> (PAR_DATA_O[23:12] == $past(PAR_DATA_I[23:12], 2)))
    else $error("upper half not staggered");
  a_err_det_sel: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (esel == 2'h0) |=> (ERR_O == $past(det_cnt_r > det_lim_r)))
    else $error("error output wrong for detected source");
  a_err_either: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (esel[1] && (cor_cnt_r > cor_lim_r)) |=> ERR_O)
    else $error("error output missed corrected source");
  a_auto_wait: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ac_state_r == deser_cfg_pkg::AC_IDLE && auto_clr && err_r && !REG_WR_I)
      |=> (ac_state_r != deser_cfg_pkg::AC_DONE && !ac_clear &&
           (det_cnt_r != 8'h00 || cor_cnt_r != 8'h00))[*8])
    else $error("counters cleared too early");
  a_auto_clear: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ac_clear |=> (det_cnt_r <= 8'h01) && (cor_cnt_r <= 8'h01))
    else $error("counters not cleared by auto-clear");
  a_no_auto: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (!auto_clr && ac_state_r != deser_cfg_pkg::AC_DONE) |=> !ac_clear)
    else $error("auto-clear fired while disabled");
  a_rsvd_zero: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !ctrl_r[5] && !src_a_r[0] && !dst_a_r[0] && !src_b_r[0] && !dst_b_r[0])
    else $error("reserved bit set");
endmodule
`default_nettype wire

// File: hw/deser_cfg_pkg.sv
// Constants shared by the output-polarity, error and address translation register bank.
// Assumes one 50 MHz system clock.
`default_nettype none
package deser_cfg_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_SRC_A = 8'h09;
  localparam logic [7:0] OFS_DST_A = 8'h0A;
  localparam logic [7:0] OFS_SRC_B = 8'h0B;
  localparam logic [7:0] OFS_DST_B = 8'h0C;
  localparam logic [7:0] OFS_DET_LIM = 8'h0F;
  localparam logic [7:0] OFS_DET_CNT = 8'h10;
  localparam logic [7:0] OFS_COR_LIM = 8'h11;
  localparam logic [7:0] OFS_COR_CNT = 8'h12;

  localparam int BIT_VS_INV = 7;
  localparam int BIT_HS_INV = 6;
  localparam int BIT_RSVD = 5;
  localparam int BIT_DRM = 4;
  localparam int BIT_STAG = 3;
  localparam int BIT_AUTO = 2;
  localparam int ESEL_LSB = 0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hDF;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] ADDR_WMASK = 8'hFE;
  localparam logic [7:0] LIM_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;

  localparam logic [1:0] ESEL_DET = 2'h0;
  localparam logic [1:0] ESEL_COR = 2'h1;

  localparam int PAR_W = 24;
  localparam int HALF_W = 12;

  localparam int CLK_PERIOD_NS = 20;
  localparam int AUTO_CLEAR_NS = 1000;
  localparam int AUTO_CLEAR_CYC = (AUTO_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] AC_LAST = 6'(AUTO_CLEAR_CYC - 1);
  localparam logic [5:0] AC_CNT_RST = 6'h00;

  typedef enum logic [1:0] {
    AC_IDLE = 2'b00,
    AC_WAIT = 2'b01,
    AC_DONE = 2'b11
  } autoclr_state_t;
endpackage
`default_nettype wire

// File: hw/addr_xlate.sv
// I2C address translator: swaps a forwarded 7-bit address for its paired destination.
// Assumes address and valid come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module addr_xlate (
  input wire logic clk_i,             // System clock
  input wire logic rst_n_i,           // Synchronised reset, active low
  input wire logic [6:0] src_a_i,     // Source address A
  input wire logic [6:0] dst_a_i,     // Destination address A
  input wire logic [6:0] src_b_i,     // Source address B
  input wire logic [6:0] dst_b_i,     // Destination address B
  input wire logic [6:0] addr_i,      // Forwarded address
  input wire logic valid_i,           // Forwarded address valid
  output logic [6:0] addr_o,          // Translated address
  output logic valid_o,               // Translated address valid
  output logic hit_o                  // A translation was applied
);
  wire hit_a = (addr_i == src_a_i);
  wire hit_b = (addr_i == src_b_i);
  // Pair A wins when both sources are equal
  wire [6:0] addr_nxt = hit_a ? dst_a_i : (hit_b ? dst_b_i : addr_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= 7'h00;
      valid_o <= 1'b0;
      hit_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        addr_o <= addr_nxt;
        hit_o <= hit_a | hit_b;
      end
    end
  end

  a_xlate_hit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (valid_i && hit_a) |=> (addr_o == $past(dst_a_i)) && hit_o && valid_o)
    else $error("translated address does not match destination A");
  a_xlate_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (valid_i && !hit_a && !hit_b) |=> (addr_o == $past(addr_i)) && !hit_o)
    else $error("unmatched address was altered");
endmodule
`default_nettype wire

// File: verif/host_model.sv
// Host-side model of the controller that programs the register bank.
// Assumes the bench calls access from one process, one access at a time.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_i,          // System clock
  input wire logic enc_i,          // Sync encoding enabled elsewhere
  input wire logic [7:0] rdata_i,  // Read data from the bank
  input wire logic ack_i,          // Access done from the bank
  output logic [7:0] addr_o,       // Register address
  output logic [7:0] wdata_o,      // Write data
  output logic wr_o,               // Write strobe
  output logic rd_o                // Read strobe
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Single-output host: never pairs with a double-input serializer
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    logic [7:0] dv;
    dv = d;
    // Match bit only with encoding off; tracking is kept on by this host
    if (is_wr && a == deser_cfg_pkg::OFS_CTRL && enc_i) dv[4] = 1'b0;
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= dv;
    wr_o <= is_wr;
    rd_o <= !is_wr;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // A released bus shows garbage, not the last value
    addr_o <= ~a;
    wdata_o <= ~dv;
    #1;
    ok = ack_i;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: verif/deser_out_err_regs_tb.sv
// Self-checking bench for the output, error and address translation register bank.
// Assumes the host model drives the register strobes; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module deser_out_err_regs_tb;
  logic clk = 1'b0, rst_b = 1'b0, enc = 1'b0, vs = 1'b0, hs = 1'b0;
  logic det = 1'b0, cor = 1'b0, fvalid = 1'b0;
  logic [23:0] pdata = 24'h000000;
  logic [6:0] faddr = 7'h00;
  logic [7:0] haddr, hwdata, rdata, q;
  logic hwr, hrd, ack, vso, hso, drm, err, xvalid, xhit, ok;
  logic [23:0] pout;
  logic [6:0] xaddr;
  int fail_count = 0, check_count = 0, cyc = 0, n;

  host_model i_host (.clk_i(clk), .enc_i(enc), .rdata_i(rdata), .ack_i(ack),
    .addr_o(haddr), .wdata_o(hwdata), .wr_o(hwr), .rd_o(hrd));
  deser_out_err_regs i_dut (.CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(haddr),
    .REG_WDATA_I(hwdata), .REG_WR_I(hwr), .REG_RD_I(hrd), .REG_RDATA_O(rdata),
    .REG_ACK_O(ack), .SYNC_ENCODE_ENABLE_I(enc), .PAR_DATA_I(pdata), .VS_I(vs),
    .HS_I(hs), .PAR_DATA_O(pout), .VS_O(vso), .HS_O(hso), .DOUBLE_RATE_MATCH_O(drm),
    .DET_ERR_I(det), .COR_ERR_I(cor), .ERR_O(err), .FWD_ADDR_I(faddr),
    .FWD_VALID_I(fvalid), .XLATE_ADDR_O(xaddr), .XLATE_VALID_O(xvalid),
    .XLATE_HIT_O(xhit));

  initial begin
    forever #10 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d, q, ok);
    check(ok, 1'b1, "write ack");
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    i_host.access(1'b0, a, 8'h00, q, ok);
    check(ok, 1'b1, "read ack");
    check(q, e, "read data");
  endtask

  // inv is {vertical, horizontal}; upper half lags one word while staggering
  task vid(input logic [23:0] w, input logic v, input logic h, input logic [1:0] inv,
           input logic stoff);
    logic [23:0] e, prev;
    prev = pdata;
    e = w;
    if (!enc) e[1:0] = w[1:0] ^ {inv[0], inv[1]};
    @(posedge clk);
    pdata <= w;
    vs <= v;
    hs <= h;
    @(posedge clk);
    #1;
    check(pout[11:0], e[11:0], "low half");
    check(vso, enc ? v ^ inv[1] : 1'b0, "vertical sync");
    check(hso, enc ? h ^ inv[0] : 1'b0, "horizontal sync");
    check(pout[23:12], stoff ? w[23:12] : prev[23:12], "upper half early");
    @(posedge clk);
    #1;
    check(pout[23:12], w[23:12], "upper half late");
  endtask

  task pulse(input logic d, input logic c);
    @(posedge clk);
    det <= d;
    cor <= c;
    @(posedge clk);
    det <= 1'b0;
    cor <= 1'b0;
  endtask

  task fwd(input logic [6:0] a, input logic [6:0] e, input logic hit);
    @(posedge clk);
    faddr <= a;
    fvalid <= 1'b1;
    @(posedge clk);
    fvalid <= 1'b0;
    faddr <= ~a;
    #1;
    check(xvalid, 1'b1, "translate valid");
    check(xaddr, e, "translated address");
    check(xhit, hit, "translate hit");
  endtask

  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h08, 8'h00);
    for (int a = 9; a <= 12; a++) rd(8'(a), 8'h00);
    rd(8'h0F, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'hDF);
    check(drm, 1'b1, "match output");
    for (int a = 9; a <= 12; a++) begin
      wr(8'(a), 8'hFF);
      rd(8'(a), 8'hFE);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      enc <= k[3];
      wr(8'h08, {k[2:1], 2'b00, k[0], 3'b000});
      vid({6{k[3:0]}} ^ 24'h5A3C96, k[1], ~k[2], k[2:1], k[0]);
    end
    $display("test video path done");
    wr(8'h0F, 8'h02);
    wr(8'h08, 8'h00);
    check(drm, 1'b0, "match output");
    repeat (3) pulse(1'b1, 1'b0);
    settle;
    check(err, 1'b1, "detected over limit");
    rd(8'h10, 8'h03);
    repeat (60) @(posedge clk);
    check(err, 1'b1, "no auto clear");
    rd(8'h10, 8'h03);
    wr(8'h08, 8'h01);
    settle;
    check(err, 1'b0, "corrected not over limit");
    pulse(1'b0, 1'b1);
    settle;
    check(err, 1'b1, "corrected over limit");
    wr(8'h11, 8'h01);
    settle;
    check(err, 1'b0, "corrected at limit");
    for (int s = 2; s < 4; s++) begin
      wr(8'h08, 8'(s));
      settle;
      check(err, 1'b1, "either source");
    end
    wr(8'h08, 8'h06);
    n = 0;
    while (err === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n >= 48 && n <= 56, 1'b1, "auto clear delay");
    rd(8'h10, 8'h00);
    rd(8'h12, 8'h00);
    $display("test error path done");
    wr(8'h09, 8'hA0);
    wr(8'h0A, 8'h22);
    wr(8'h0B, 8'h66);
    wr(8'h0C, 8'h44);
    fwd(7'h50, 7'h11, 1'b1);
    fwd(7'h33, 7'h22, 1'b1);
    fwd(7'h7F, 7'h7F, 1'b0);
    wr(8'h0B, 8'hA0);
    fwd(7'h50, 7'h11, 1'b1);
    $display("test translator done");
    complete_run;
  end
endmodule
`default_nettype wire
